// ==== design/rsc_pkg.sv ====
// constants and types for the refresh and suspend control block
package rsc_pkg;

  // ----------------------------------------------------------------
  // configuration access
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_INDEX_PORT = 8'hEC;
  localparam logic [7:0] CFG_DATA_PORT = 8'hED;
  localparam logic [7:0] REFRESH_POWER_CONTROL_INDEX = 8'h06;
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

  // ----------------------------------------------------------------
  // field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] REF_TYPE_RAS_ONLY = 2'h0;
  localparam logic [1:0] REF_TYPE_CBR = 2'h1;
  localparam logic [1:0] REF_TYPE_CBR_SELF = 2'h2;
  localparam logic [1:0] REF_TYPE_NONE = 2'h3;
  localparam logic [1:0] REF_INT_STD = 2'h0;
  localparam logic [1:0] REF_INT_SLOW = 2'h1;
  localparam logic [1:0] REF_INT_SLOW2 = 2'h2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint CLK_PERIOD_NS = 40;
  localparam longint LOW_CLK_HZ = 32768;
  localparam longint NS_PER_S = 1000000000;
  localparam longint REF_STD_NS = 15625;
  localparam longint REF_SLOW_NS = 125000;
  localparam longint REF_SLOW2_NS = 250000;
  localparam int CNT_W = 14;
  localparam int RESET_PULSE_CYCLES = 16;
  localparam int RST_CNT_W = 5;

  // longest time: round down, never below one
  function automatic int ns_to_cycles(longint ns);
    longint c;
    c = ns / CLK_PERIOD_NS;
    return (c < 1) ? 1 : int'(c);
  endfunction

  function automatic int ns_to_ticks32k(longint ns);
    longint t;
    t = (ns * LOW_CLK_HZ) / NS_PER_S;
    return (t < 1) ? 1 : int'(t);
  endfunction

  localparam int REF_STD_CYCLES = ns_to_cycles(REF_STD_NS);
  localparam int REF_SLOW_CYCLES = ns_to_cycles(REF_SLOW_NS);
  localparam int REF_SLOW2_CYCLES = ns_to_cycles(REF_SLOW2_NS);
  localparam int REF_STD_TICKS = ns_to_ticks32k(REF_STD_NS);
  localparam int REF_SLOW_TICKS = ns_to_ticks32k(REF_SLOW_NS);
  localparam int REF_SLOW2_TICKS = ns_to_ticks32k(REF_SLOW2_NS);

  // ----------------------------------------------------------------
  // carriers and state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic suspend_arm;
    logic processor_off_in_suspend;
    logic soft_reset_pending;
    logic halt_detected;
    logic [1:0] refresh_type;
    logic [1:0] refresh_interval;
  } rsc_ctl_type;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rsc_io_req_type;

  typedef struct packed {
    logic strobe;
    logic cbr;
    logic self_refresh;
    logic timer_tick;
  } rsc_refresh_type;

  typedef struct packed {
    logic suspended;
    logic cpu_off_state;
    logic cpu_on_state;
    logic clocks_stopped;
    logic leakage_ctl;
    logic timebase_32k;
  } rsc_power_type;

  typedef struct packed {
    rsc_ctl_type ctl;
    logic [7:0] index;
    logic [7:0] rdata;
    logic rvalid;
    logic [1:0] susp_sync;
    logic [1:0] sysrst_sync;
    logic [2:0] nmi_sync;
    logic [2:0] k32_sync;
    logic suspended;
    logic [RST_CNT_W-1:0] rst_cnt;
    logic cpu_rst;
    logic npx_rst;
    logic ref_strobe;
  } rsc_main_state_type;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic tick;
  } rsc_timer_state_type;

  localparam rsc_ctl_type CTL_RESET = 8'h00;
  localparam rsc_main_state_type MAIN_STATE_RESET = '0;
  localparam rsc_timer_state_type TIMER_STATE_RESET = '0;

endpackage

// ==== design/rsc_refresh_suspend_control.sv ====
// refresh and suspend control register with its suspend, reset and refresh logic
module rsc_refresh_suspend_control import rsc_pkg::*; #(
  parameter int SLOW2_CYCLES = REF_SLOW2_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset,
  input rsc_io_req_type io_req,
  output logic [7:0] io_rdata,
  output logic io_rdata_valid,
  input wire logic suspend_req_n,
  input wire logic sys_reset_n,
  input wire logic nmi,
  input wire logic clk_32k,
  input wire logic halt_cycle,
  input wire logic inta_cycle,
  input wire logic kbd_reset_req,
  input wire logic porta_reset_req,
  input wire logic special_feature_reset,
  output logic processor_reset_out,
  output logic coprocessor_reset_out,
  output rsc_power_type power,
  output rsc_refresh_type refresh
);

  rsc_main_state_type q;
  rsc_main_state_type d;
  rsc_ctl_type wctl;
  logic pin_low;
  logic sys_rst_low;
  logic nmi_rise;
  logic tick_32k;
  logic timer_tick;
  logic soft_req;
  logic start_soft;
  logic start_off;
  logic leaving;
  logic ctl_sel;

  // ----------------------------------------------------------------
  // refresh timer
  // ----------------------------------------------------------------
  rsc_refresh_timer #(
    .SLOW2_CYCLES(SLOW2_CYCLES)
  ) u_timer (
    .core_clk(core_clk),
    .reset(reset),
    .interval_sel(q.ctl.refresh_interval),
    .use_32k(q.suspended),
    .tick_32k(tick_32k),
    .timer_tick(timer_tick)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    wctl = rsc_ctl_type'(io_req.wdata);
    // suspend and reset pins cross through two flops, second stage looked at; nmi and 32 kHz through three for edge detect
    d.susp_sync = {q.susp_sync[0], suspend_req_n};
    d.sysrst_sync = {q.sysrst_sync[0], sys_reset_n};
    d.nmi_sync = {q.nmi_sync[1:0], nmi};
    d.k32_sync = {q.k32_sync[1:0], clk_32k};
    pin_low = !q.susp_sync[1];
    sys_rst_low = !q.sysrst_sync[1];
    nmi_rise = q.nmi_sync[1] && !q.nmi_sync[2];
    tick_32k = q.k32_sync[1] && !q.k32_sync[2];
    ctl_sel = (io_req.addr == CFG_DATA_PORT) && (q.index == REFRESH_POWER_CONTROL_INDEX);

    // configuration port access
    d.rvalid = io_req.rd;
    if (io_req.wr) begin
      if (io_req.addr == CFG_INDEX_PORT) begin
        d.index = io_req.wdata;
      end else if (ctl_sel) begin
        d.ctl.suspend_arm = wctl.suspend_arm;
        d.ctl.processor_off_in_suspend = wctl.processor_off_in_suspend;
        d.ctl.refresh_type = wctl.refresh_type;
        // status bits are not taken from the write
        d.ctl.refresh_interval = wctl.refresh_interval;
      end
    end
    if (io_req.rd) begin
      if (io_req.addr == CFG_INDEX_PORT) begin
        d.rdata = q.index;
      end else if (ctl_sel) begin
        d.rdata = q.ctl;
      end else begin
        d.rdata = UNMAPPED_READ_VALUE;
      end
    end

    // suspend: pin ignored unless armed
    d.suspended = q.ctl.suspend_arm && pin_low;
    leaving = q.suspended && !d.suspended;

    // processor and coprocessor reset pulses
    soft_req = kbd_reset_req || porta_reset_req || special_feature_reset;
    start_off = leaving && q.ctl.processor_off_in_suspend;
    start_soft = q.ctl.soft_reset_pending && !q.cpu_rst;
    if (sys_rst_low) begin
      d.cpu_rst = 1'b1;
      d.npx_rst = 1'b1;
      d.rst_cnt = RST_CNT_W'(RESET_PULSE_CYCLES);
    end else if (start_off) begin
      d.cpu_rst = 1'b1;
      d.npx_rst = 1'b1;
      d.rst_cnt = RST_CNT_W'(RESET_PULSE_CYCLES);
    end else if (start_soft) begin
      // a soft reset only restarts the processor
      d.cpu_rst = 1'b1;
      d.rst_cnt = RST_CNT_W'(RESET_PULSE_CYCLES);
    end else if (q.rst_cnt > RST_CNT_W'(1)) begin
      d.rst_cnt = q.rst_cnt - RST_CNT_W'(1);
    end else begin
      d.rst_cnt = '0;
      d.cpu_rst = 1'b0;
      d.npx_rst = 1'b0;
    end

    // pending soft reset: the reset edge clears even a request in that cycle
    if (soft_req) begin
      d.ctl.soft_reset_pending = 1'b1;
    end
    if (d.cpu_rst && !q.cpu_rst) begin
      d.ctl.soft_reset_pending = 1'b0;
    end

    // halt flag: edge clears lose to a same-cycle halt, reset levels hold it low
    if (nmi_rise || inta_cycle) begin
      d.ctl.halt_detected = 1'b0;
    end
    if (halt_cycle) begin
      d.ctl.halt_detected = 1'b1;
    end
    if (sys_rst_low || q.cpu_rst) begin
      d.ctl.halt_detected = 1'b0;
    end

    // refresh request, none for static RAM or during self-refresh
    d.ref_strobe = timer_tick && (q.ctl.refresh_type != REF_TYPE_NONE) &&
                   !((q.ctl.refresh_type == REF_TYPE_CBR_SELF) && q.suspended);
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      q <= MAIN_STATE_RESET;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign io_rdata = q.rdata;
  assign io_rdata_valid = q.rvalid;
  assign processor_reset_out = q.cpu_rst;
  assign coprocessor_reset_out = q.npx_rst;

  assign power.suspended = q.suspended;
  assign power.cpu_off_state = q.suspended && q.ctl.processor_off_in_suspend;
  assign power.cpu_on_state = q.suspended && !q.ctl.processor_off_in_suspend;
  assign power.clocks_stopped = q.suspended;
  assign power.leakage_ctl = q.suspended;
  assign power.timebase_32k = q.suspended;

  assign refresh.strobe = q.ref_strobe;
  // ras-only for 00, cas-before-ras for 01 and 10
  assign refresh.cbr = (q.ctl.refresh_type == REF_TYPE_CBR) || (q.ctl.refresh_type == REF_TYPE_CBR_SELF);
  assign refresh.self_refresh = (q.ctl.refresh_type == REF_TYPE_CBR_SELF) && q.suspended;
  // the timer keeps running whatever the type
  assign refresh.timer_tick = timer_tick;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  sequence s_both_resets;
    (processor_reset_out && coprocessor_reset_out)[*8];
  endsequence

  sequence s_leave_suspend;
    q.suspended && !(q.ctl.suspend_arm && !q.susp_sync[1]);
  endsequence

  a_arm_gates_suspend: assert property (
    !q.ctl.suspend_arm |=> !power.suspended)
    else $error("suspend active while not armed");

  a_enter_suspend: assert property (
    (q.ctl.suspend_arm && !q.susp_sync[1] && $stable(q.ctl.suspend_arm)) |=> power.suspended)
    else $error("armed suspend with pin low not entered");

  a_suspend_features: assert property (
    power.suspended |-> (power.timebase_32k && power.clocks_stopped && power.leakage_ctl))
    else $error("suspend features not all on");

  a_off_exit_reset: assert property (
    (s_leave_suspend and q.ctl.processor_off_in_suspend) |=> s_both_resets)
    else $error("processor-off exit without reset pulse");

  a_on_exit_quiet: assert property (
    (s_leave_suspend and (!q.ctl.processor_off_in_suspend && q.sysrst_sync[1] && !q.npx_rst)) |=>
      !coprocessor_reset_out)
    else $error("processor-on exit pulsed coprocessor reset");

  a_pending_set: assert property (
    (kbd_reset_req || porta_reset_req || special_feature_reset) &&
      (q.cpu_rst || (q.sysrst_sync[1] && !q.ctl.soft_reset_pending && !q.suspended)) |=> q.ctl.soft_reset_pending)
    else $error("soft reset request not flagged");

  a_pending_clear: assert property (
    $rose(processor_reset_out) |-> !q.ctl.soft_reset_pending)
    else $error("pending flag survived processor reset edge");

  a_halt_set: assert property (
    (halt_cycle && q.sysrst_sync[1] && !q.cpu_rst) |=> q.ctl.halt_detected)
    else $error("halt cycle not flagged");

  a_halt_clear: assert property (
    (inta_cycle && !halt_cycle) || q.cpu_rst |=> !q.ctl.halt_detected)
    else $error("halt flag not cleared");

  a_sram_no_refresh: assert property (
    (q.ctl.refresh_type == REF_TYPE_NONE) && $stable(q.ctl.refresh_type) |-> !refresh.strobe)
    else $error("refresh issued with refresh disabled");

  a_self_refresh_mode: assert property (
    (power.suspended && q.ctl.refresh_type == REF_TYPE_CBR_SELF && $past(q.suspended) &&
      $stable(q.ctl.refresh_type)) |->
      (refresh.self_refresh && !refresh.strobe))
    else $error("self-refresh not in effect during suspend");

  a_status_read_only: assert property (
    (io_req.wr && ctl_sel && !halt_cycle && !inta_cycle && !nmi_rise && q.sysrst_sync[1] && !q.cpu_rst) |=>
      $stable(q.ctl.halt_detected))
    else $error("software write changed halt flag");

  a_pending_read_only: assert property (
    (io_req.wr && ctl_sel && !soft_req && !q.ctl.soft_reset_pending) |=> !q.ctl.soft_reset_pending)
    else $error("software write set pending flag");

  a_nmi_clears_halt: assert property (
    (nmi_rise && !halt_cycle) |=> !q.ctl.halt_detected)
    else $error("halt flag survived nmi edge");

  // quiet request: no pulse running, nothing pending, no other reset source
  sequence s_soft_request;
    (kbd_reset_req || porta_reset_req || special_feature_reset) && !q.cpu_rst &&
      !q.ctl.soft_reset_pending && q.sysrst_sync[1] && !q.suspended;
  endsequence

  sequence s_soft_pulse_start;
    (q.ctl.soft_reset_pending && !processor_reset_out) ##1 (processor_reset_out && !q.ctl.soft_reset_pending);
  endsequence

  a_soft_reset_seq: assert property (
    s_soft_request |=> s_soft_pulse_start)
    else $error("soft reset request did not start a processor reset");

  a_read_latency: assert property (
    io_req.rd |=> io_rdata_valid)
    else $error("read answer missing");

  a_valid_one_cycle: assert property (
    !io_req.rd |=> !io_rdata_valid)
    else $error("read valid without a read");

  a_ctl_read_data: assert property (
    (io_req.rd && ctl_sel) |=> (io_rdata == $past(q.ctl)))
    else $error("control read returned wrong data");

  a_index_read: assert property (
    (io_req.rd && io_req.addr == CFG_INDEX_PORT) |=> (io_rdata == $past(q.index)))
    else $error("index read returned wrong data");

  a_unmapped_read: assert property (
    (io_req.rd && io_req.addr != CFG_INDEX_PORT && !ctl_sel) |=> (io_rdata == UNMAPPED_READ_VALUE))
    else $error("unmapped read returned data");

  a_index_write: assert property (
    (io_req.wr && io_req.addr == CFG_INDEX_PORT) |=> (q.index == $past(io_req.wdata)))
    else $error("index write did not land");

  a_ctl_write_lands: assert property (
    (io_req.wr && ctl_sel) |=> ({q.ctl.suspend_arm, q.ctl.processor_off_in_suspend, q.ctl.refresh_type,
      q.ctl.refresh_interval} == $past({wctl.suspend_arm, wctl.processor_off_in_suspend, wctl.refresh_type,
      wctl.refresh_interval})))
    else $error("control write did not land");

  a_power_off_idle: assert property (
    !power.suspended |-> !(power.clocks_stopped || power.leakage_ctl || power.timebase_32k ||
      power.cpu_off_state || power.cpu_on_state || refresh.self_refresh))
    else $error("suspend feature on outside suspend");

  a_suspend_option: assert property (
    power.suspended |-> ((power.cpu_off_state == q.ctl.processor_off_in_suspend) &&
      (power.cpu_on_state == !q.ctl.processor_off_in_suspend)))
    else $error("suspend pin state option wrong");

  a_ras_only_select: assert property (
    (q.ctl.refresh_type == REF_TYPE_RAS_ONLY) |-> (!refresh.cbr && !refresh.self_refresh))
    else $error("ras-only type not decoded");

  a_cbr_select: assert property (
    (q.ctl.refresh_type == REF_TYPE_CBR) |-> (refresh.cbr && !refresh.self_refresh))
    else $error("cas-before-ras type not decoded");

  a_cbr_self_normal: assert property (
    (q.ctl.refresh_type == REF_TYPE_CBR_SELF && !power.suspended) |-> (refresh.cbr && !refresh.self_refresh))
    else $error("self-refresh type wrong outside suspend");

  a_tick_refreshes: assert property (
    (timer_tick && (q.ctl.refresh_type == REF_TYPE_RAS_ONLY || q.ctl.refresh_type == REF_TYPE_CBR)) |=>
      refresh.strobe)
    else $error("interval tick gave no refresh");

  a_strobe_needs_tick: assert property (
    refresh.strobe |-> $past(refresh.timer_tick))
    else $error("refresh strobe without interval tick");

endmodule

// ==== design/rsc_refresh_timer.sv ====
// refresh interval timer, on core clock or on 32 kHz ticks
module rsc_refresh_timer import rsc_pkg::*; #(
  parameter int SLOW2_CYCLES = REF_SLOW2_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [1:0] interval_sel,
  input wire logic use_32k,
  input wire logic tick_32k,
  output logic timer_tick
);

  rsc_timer_state_type q;
  rsc_timer_state_type d;
  logic [CNT_W-1:0] limit;
  logic step;

  // ----------------------------------------------------------------
  // interval selection
  // ----------------------------------------------------------------
  // reserved code falls back to the standard period
  function automatic logic [CNT_W-1:0] pick(logic [1:0] sel, int norm, int slow, int slow2);
    unique case (sel)
      REF_INT_SLOW: return CNT_W'(slow);
      REF_INT_SLOW2: return CNT_W'(slow2);
      default: return CNT_W'(norm);
    endcase
  endfunction

  always_comb begin
    d = q;
    d.tick = 1'b0;
    // same interval code in every mode, only the timebase changes
    limit = use_32k ? pick(interval_sel, REF_STD_TICKS, REF_SLOW_TICKS, REF_SLOW2_TICKS)
                    : pick(interval_sel, REF_STD_CYCLES, REF_SLOW_CYCLES, SLOW2_CYCLES);
    step = use_32k ? tick_32k : 1'b1;
    if (step) begin
      // >= so a shorter interval written mid-count takes effect at once
      if (q.cnt >= limit - CNT_W'(1)) begin
        d.cnt = '0;
        d.tick = 1'b1;
      end else begin
        d.cnt = q.cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      q <= TIMER_STATE_RESET;
    end else begin
      q <= d;
    end
  end

  assign timer_tick = q.tick;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_tick_spacing_std: assert property (
    @(posedge core_clk) disable iff (reset)
    (timer_tick && !use_32k && interval_sel == REF_INT_STD && $stable(use_32k)) |=>
      (!timer_tick)[*8])
    else $error("refresh ticks closer than the standard interval");

endmodule

// ==== dv/rsc_dram_model.sv ====
// far-side model: dram refresh observer and processor reset watcher
module rsc_dram_model import rsc_pkg::*; (
  input wire logic core_clk,
  input wire logic reset,
  input rsc_refresh_type refresh,
  input wire logic processor_reset_out,
  output int last_gap,
  output int strobe_cnt,
  output int tick_cnt,
  output int rst_width
);
  timeunit 1ns;
  timeprecision 1ns;
  int gap_q;
  int width_q;

  // ----------------------------------------
  // refresh spacing as a dram bank sees it
  // ----------------------------------------
  // a bank only cares about strobes; self refresh needs no strobes at all
  always @(posedge core_clk) begin
    if (reset) begin
      gap_q <= 0;
      width_q <= 0;
      last_gap <= 0;
      strobe_cnt <= 0;
      tick_cnt <= 0;
      rst_width <= 0;
    end else begin
      gap_q <= (refresh.strobe === 1'b1) ? 1 : gap_q + 1;
      if (refresh.strobe === 1'b1) begin
        last_gap <= gap_q;
        strobe_cnt <= strobe_cnt + 1;
      end
      if (refresh.timer_tick === 1'b1) begin
        tick_cnt <= tick_cnt + 1;
      end
      // processor side: width of each reset pulse it receives
      width_q <= (processor_reset_out === 1'b1) ? width_q + 1 : 0;
      if (processor_reset_out !== 1'b1 && width_q != 0) begin
        rst_width <= width_q;
      end
    end
  end
endmodule

// ==== dv/rsc_refresh_suspend_control_tb.sv ====
// self-checking bench for the refresh and suspend control block
module rsc_refresh_suspend_control_tb import rsc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // short slow interval keeps the run brief
  localparam int SLOW2 = 700;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  rsc_io_req_type io_req = '0;
  logic [7:0] io_rdata;
  logic io_rdata_valid;
  logic suspend_req_n = 1'b1;
  logic sys_reset_n = 1'b1;
  logic nmi = 1'b0;
  logic clk_32k = 1'b0;
  logic halt_cycle = 1'b0;
  logic inta_cycle = 1'b0;
  logic kbd_reset_req = 1'b0;
  logic porta_reset_req = 1'b0;
  logic special_feature_reset = 1'b0;
  logic processor_reset_out;
  logic coprocessor_reset_out;
  rsc_power_type power;
  rsc_refresh_type refresh;
  int last_gap;
  int strobe_cnt;
  int tick_cnt;
  int rst_width;
  int mismatches = 0;
  int samples_checked = 0;
  int cnt_s;
  int cnt_t;
  int gaps[3] = '{390, 3125, SLOW2};
  logic [7:0] exp_q[$];
  logic [7:0] exp_reg;
  logic [7:0] v;

  rsc_refresh_suspend_control #(.SLOW2_CYCLES(SLOW2)) dut_u (
    .core_clk(core_clk), .reset(reset), .io_req(io_req), .io_rdata(io_rdata),
    .io_rdata_valid(io_rdata_valid), .suspend_req_n(suspend_req_n), .sys_reset_n(sys_reset_n),
    .nmi(nmi), .clk_32k(clk_32k), .halt_cycle(halt_cycle), .inta_cycle(inta_cycle),
    .kbd_reset_req(kbd_reset_req), .porta_reset_req(porta_reset_req),
    .special_feature_reset(special_feature_reset), .processor_reset_out(processor_reset_out),
    .coprocessor_reset_out(coprocessor_reset_out), .power(power), .refresh(refresh)
  );

  rsc_dram_model far_u (
    .core_clk(core_clk), .reset(reset), .refresh(refresh), .processor_reset_out(processor_reset_out),
    .last_gap(last_gap), .strobe_cnt(strobe_cnt), .tick_cnt(tick_cnt), .rst_width(rst_width)
  );

  initial forever #20 core_clk = ~core_clk;
  // 32 kHz source, free running; odd offset keeps its edges off the core clock edges
  initial begin
    #7;
    forever #15258 clk_32k = ~clk_32k;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic wrap_up();
    if (mismatches == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic cycles(int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic bus(logic rd, logic wr, logic [7:0] addr, logic [7:0] data);
    @(posedge core_clk);
    io_req <= '{rd: rd, wr: wr, addr: addr, wdata: data};
    @(posedge core_clk);
    io_req <= '0;
  endtask

  // flag bits never come back from a write, so only control bits are kept
  task automatic wr_reg(logic [7:0] val);
    bus(1'b0, 1'b1, CFG_INDEX_PORT, REFRESH_POWER_CONTROL_INDEX);
    bus(1'b0, 1'b1, CFG_DATA_PORT, val);
    exp_reg = val & 8'hCF;
  endtask

  task automatic rd_port(logic [7:0] addr, logic [7:0] exp);
    exp_q.push_back(exp);
    bus(1'b1, 1'b0, addr, 8'h00);
  endtask

  task automatic pulse(int sel);
    @(posedge core_clk);
    case (sel)
      0: kbd_reset_req <= 1'b1;
      1: porta_reset_req <= 1'b1;
      2: special_feature_reset <= 1'b1;
      default: halt_cycle <= 1'b1;
    endcase
    @(posedge core_clk);
    {kbd_reset_req, porta_reset_req, special_feature_reset, halt_cycle} <= 4'h0;
  endtask

  task automatic wait_sig(int sel, int bound);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < bound && !hit; i++) begin
      @(posedge core_clk);
      case (sel)
        0: hit = refresh.strobe === 1'b1;
        1: hit = processor_reset_out === 1'b1;
        2: hit = power.suspended === 1'b1;
        default: hit = power.suspended === 1'b0;
      endcase
    end
    if (!hit) begin
      mismatches++;
      wrap_up();
    end
  endtask

  // ----------------------------------------
  // read monitor: oldest note against each returned byte
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (io_rdata_valid === 1'b1) begin
      if (exp_q.size() == 0) check("unexpected read", 32'h1, 32'h0);
      else check("read data", 32'(io_rdata), 32'(exp_q.pop_front()));
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h2912));
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    cycles(30);
    bus(1'b0, 1'b1, CFG_INDEX_PORT, REFRESH_POWER_CONTROL_INDEX);
    rd_port(CFG_DATA_PORT, 8'h00);
    rd_port(8'h80, UNMAPPED_READ_VALUE);
    for (int i = 0; i < 6; i++) begin
      v = 8'($urandom());
      if (v[1:0] == 2'h3) v[1:0] = 2'h2;
      wr_reg(v);
      rd_port(CFG_DATA_PORT, exp_reg);
    end
    bus(1'b0, 1'b1, CFG_INDEX_PORT, 8'h07);
    bus(1'b0, 1'b1, CFG_DATA_PORT, 8'hFF);
    rd_port(CFG_INDEX_PORT, 8'h07);
    rd_port(CFG_DATA_PORT, 8'h00);
    bus(1'b0, 1'b1, CFG_INDEX_PORT, REFRESH_POWER_CONTROL_INDEX);
    rd_port(CFG_DATA_PORT, exp_reg);
    // soft reset from each source
    wr_reg(8'h00);
    for (int s = 0; s < 3; s++) begin
      pulse(s);
      wait_sig(1, 10);
      check("coprocessor reset", 32'(coprocessor_reset_out), 32'h0);
      cycles(24);
      check("reset width", rst_width, RESET_PULSE_CYCLES);
      rd_port(CFG_DATA_PORT, 8'h00);
    end
    // halt flag, cleared by each source in turn
    for (int c = 0; c < 3; c++) begin
      pulse(3);
      cycles(2);
      rd_port(CFG_DATA_PORT, 8'h10);
      @(posedge core_clk);
      case (c)
        0: inta_cycle <= 1'b1;
        1: nmi <= 1'b1;
        default: sys_reset_n <= 1'b0;
      endcase
      cycles(6);
      {inta_cycle, nmi, sys_reset_n} <= 3'b001;
      cycles(30);
      rd_port(CFG_DATA_PORT, 8'h00);
    end
    // suspend: unarmed, then processor off, then processor on
    suspend_req_n <= 1'b0;
    cycles(8);
    check("unarmed suspend", 32'(power.suspended), 32'h0);
    wr_reg(8'hC8);
    wait_sig(2, 8);
    check("suspend power", 32'({power.timebase_32k, power.clocks_stopped, power.leakage_ctl}), 32'h7);
    check("cpu off state", 32'(power.cpu_off_state), 32'h1);
    check("self refresh", 32'(refresh.self_refresh), 32'h1);
    suspend_req_n <= 1'b1;
    wait_sig(3, 8);
    check("exit resets", 32'({processor_reset_out, coprocessor_reset_out}), 32'h3);
    cycles(30);
    wr_reg(8'h85);
    suspend_req_n <= 1'b0;
    wait_sig(2, 8);
    check("cpu on state", 32'(power.cpu_on_state), 32'h1);
    repeat (3) wait_sig(0, 8000);
    cycles(1);
    check("suspend gap", 32'(last_gap > 3049 && last_gap < 3055), 32'h1);
    suspend_req_n <= 1'b1;
    wait_sig(3, 8);
    cycles(2);
    check("no exit resets", 32'({processor_reset_out, coprocessor_reset_out}), 32'h0);
    // refresh type decode
    for (int t = 0; t < 3; t++) begin
      wr_reg({4'h0, 2'(t), 2'h0});
      cycles(2);
      check("cbr select", 32'({refresh.cbr, refresh.self_refresh}), 32'({t != 0, 1'b0}));
    end
    // refresh interval per code
    for (int n = 0; n < 3; n++) begin
      wr_reg({6'h01, 2'(n)});
      repeat (3) wait_sig(0, 4000);
      cycles(1);
      check("refresh gap", last_gap, gaps[n]);
    end
    // no refresh, timer still running
    wr_reg(8'h0C);
    cycles(2);
    cnt_s = strobe_cnt;
    cnt_t = tick_cnt;
    cycles(900);
    check("no refresh", strobe_cnt - cnt_s, 32'h0);
    check("timer runs", 32'(tick_cnt > cnt_t + 1), 32'h1);
    cycles(4);
    check("reads pending", exp_q.size(), 32'h0);
    wrap_up();
  end
endmodule
